// >>> sbt_regs.svh
// Register offsets, field positions, reset values and timing counts
// Operation
// - Wide mode: low read copies high into buffer
// - Wide mode: low write loads high from buffer
// - Wide mode: live high byte never accessed directly
// - Narrow mode: two independent byte accesses
// - High write keeps prescaler; low write clears
// - Status bit shows clock from oscillator
// - Prescale field selects 1:1 to 1:8
// - Oscillator enable bit powers oscillator
// - Sync bit in external mode keeps the synchroniser and only drops the compare trigger
// - Source select: internal quarter clock or external input (pin, or oscillator when enabled)
// - Run bit starts and stops counting
// - External mode counts pin or oscillator rises
// - Enabled counter forces shared pins to inputs
// - Rollover to zero latches overflow flag
// - Compare trigger clears counter; writes win
`ifndef SBT_REGS_SVH
`define SBT_REGS_SVH
`define SBT_ADDR_CONTROL 8'h00
`define SBT_ADDR_LOW 8'h04
`define SBT_ADDR_HIGH 8'h08
`define SBT_ADDR_STATUS 8'h0c
`define SBT_ADDR_MASK 8'h10
`define SBT_CTL_RESET 8'h00
`define SBT_BIT_WIDE 7
`define SBT_BIT_SYSCLK 6
`define SBT_BIT_PS_HI 5
`define SBT_BIT_PS_LO 4
`define SBT_BIT_OSC_EN 3
`define SBT_BIT_SYNC_BYP 2
`define SBT_BIT_SRC 1
`define SBT_BIT_RUN 0
`define SBT_QUARTER_DIV 2'h3
`define SBT_COUNT_MAX 16'hffff
`endif

// >>> sbt_pkg.sv
// Types shared by the timer counter files
package sbt_pkg;
    typedef enum logic [1:0] {
        SBT_PS_1 = 2'h0,
        SBT_PS_2 = 2'h1,
        SBT_PS_4 = 2'h2,
        SBT_PS_8 = 2'h3
    } sbt_prescale_type;
endpackage

// >>> sbt_edge_sync.sv
// Two-stage synchroniser with rising edge detector
`timescale 1ns/1ps
`default_nettype none
module sbt_edge_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_level,
    output logic rise_pulse
);
    // Chain: first stage feeds only the second
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    assign sync_level = sync_reg;
    // Edge seen only after the second stage
    assign rise_pulse = sync_reg & ~last_reg;
endmodule // sbt_edge_sync
`default_nettype wire

// >>> sbt_timer.sv
// Sixteen bit timer counter with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "sbt_regs.svh"
module sbt_timer
    import sbt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_pin,
    input wire logic lp_osc_in,
    input wire logic sysclk_src_lp,
    input wire logic compare_trigger,
    output logic lp_osc_power,
    output logic pins_forced_input,
    output logic irq
);
    // ****************************************
    // Bus decode
    // ****************************************
    logic acc; // Access phase
    logic wr_ok; // Write takes effect
    logic rd_setup; // Read setup: data staged for the access phase
    assign acc = psel & penable;
    assign wr_ok = acc & pwrite;
    // Zero wait states, so read data must stand before the access edge
    assign rd_setup = psel & ~penable & ~pwrite;

    // ****************************************
    // State
    // ****************************************
    logic [7:0] ctl_reg, ctl_next; // Control register
    logic [15:0] cnt_reg, cnt_next; // Live count
    logic [7:0] hbuf_reg, hbuf_next; // High byte buffer
    logic [2:0] ps_reg, ps_next; // Prescaler count
    logic [1:0] q_reg, q_next; // Quarter clock divider
    logic stat_reg, stat_next; // Sticky overflow flag
    logic mask_reg, mask_next; // Overflow enable
    logic [31:0] rd_reg, rd_next; // Read data
    logic irq_reg, irq_next; // Interrupt line
    logic sys_reg, sys_next; // Clock status resync
    logic sysm_reg; // Status first stage
    logic pin_rise; // Synchronised pin rise
    logic osc_rise; // Synchronised oscillator rise
    logic sel_rise; // Rise of the chosen external input
    logic trig_ok; // Trigger allowed in this mode
    logic tick; // Count source event
    logic ps_hit; // Prescaler output
    logic [2:0] ps_top; // Prescaler terminal value
    logic wide; // Wide access mode

    assign wide = ctl_reg[`SBT_BIT_WIDE];

    // Pin and oscillator each get their own synchroniser, so that
    // nothing but flip-flops ever looks at an asynchronous input
    sbt_edge_sync u_sync_pin (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ext_count_pin),
        .sync_level(),
        .rise_pulse(pin_rise)
    );
    // Oscillator input, same two-stage chain
    sbt_edge_sync u_sync_osc (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(lp_osc_in),
        .sync_level(),
        .rise_pulse(osc_rise)
    );
    // Chosen after edge detection, so switching makes no false edge
    assign sel_rise = ctl_reg[`SBT_BIT_OSC_EN] ? osc_rise
                                                : pin_rise;
    // Trigger is dropped only for the unsynchronised external count
    assign trig_ok = compare_trigger
                     & ~(ctl_reg[`SBT_BIT_SRC] & ctl_reg[`SBT_BIT_SYNC_BYP]);

    // Clock status input, first stage; only sys_reg reads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysm_reg <= 1'b0;
        end else begin
            sysm_reg <= sysclk_src_lp;
        end
    end

    // ****************************************
    // Source and prescaler
    // ****************************************
    always_comb begin
        // Internal source ignores the sync bit
        if (!ctl_reg[`SBT_BIT_SRC]) begin
            tick = (q_reg == `SBT_QUARTER_DIV);
        end else begin
            // One clock only: the unsynchronised setting cannot count
            // without pclk, so both settings share the synchroniser and
            // the bypass bit only drops the compare trigger
            tick = sel_rise;
        end
        case (sbt_prescale_type'(ctl_reg[`SBT_BIT_PS_HI:`SBT_BIT_PS_LO]))
            SBT_PS_8: ps_top = 3'h7;
            SBT_PS_4: ps_top = 3'h3;
            SBT_PS_2: ps_top = 3'h1;
            default: ps_top = 3'h0;
        endcase
        ps_hit = ctl_reg[`SBT_BIT_RUN] & tick & (ps_reg == ps_top);
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        ctl_next = ctl_reg;
        cnt_next = cnt_reg;
        hbuf_next = hbuf_reg;
        ps_next = ps_reg;
        stat_next = stat_reg;
        mask_next = mask_reg;
        rd_next = rd_reg;
        q_next = q_reg + 2'd1;
        sys_next = sysm_reg;
        // Counting, then trigger, then software write, by priority
        if (ctl_reg[`SBT_BIT_RUN] && tick) begin
            ps_next = ps_hit ? 3'h0 : ps_reg + 3'h1;
        end
        if (ps_hit) begin
            cnt_next = cnt_reg + 16'h0001;
        end
        if (trig_ok) begin
            cnt_next = 16'h0000;
        end
        // Flag from counting rollover only, never from the trigger
        if (ps_hit && cnt_reg == `SBT_COUNT_MAX) begin
            stat_next = 1'b1;
        end
        if (wr_ok) begin
            if (paddr == `SBT_ADDR_CONTROL) begin
                ctl_next = pwdata[7:0];
                ctl_next[`SBT_BIT_SYSCLK] = ctl_reg[`SBT_BIT_SYSCLK];
            end else if (paddr == `SBT_ADDR_LOW) begin
                cnt_next[7:0] = pwdata[7:0];
                ps_next = 3'h0;
                if (wide) begin
                    cnt_next[15:8] = hbuf_reg;
                end
            end else if (paddr == `SBT_ADDR_HIGH) begin
                // Prescaler untouched on high writes
                if (wide) begin
                    hbuf_next = pwdata[7:0];
                end else begin
                    cnt_next[15:8] = pwdata[7:0];
                end
            end else if (paddr == `SBT_ADDR_STATUS) begin
                // Set beats the clear in the same cycle
                if (pwdata[0] && !(ps_hit && cnt_reg == `SBT_COUNT_MAX)) begin
                    stat_next = 1'b0;
                end
            end else if (paddr == `SBT_ADDR_MASK) begin
                mask_next = pwdata[0];
            end
        end
        // Read data and the wide-mode buffer copy share one edge, so the
        // two bytes always come from the same count
        if (rd_setup) begin
            rd_next = 32'h0000_0000;
            if (paddr == `SBT_ADDR_CONTROL) begin
                rd_next[7:0] = ctl_reg;
            end else if (paddr == `SBT_ADDR_LOW) begin
                rd_next[7:0] = cnt_reg[7:0];
                if (wide) begin
                    hbuf_next = cnt_reg[15:8];
                end
            end else if (paddr == `SBT_ADDR_HIGH) begin
                rd_next[7:0] = wide ? hbuf_reg : cnt_reg[15:8];
            end else if (paddr == `SBT_ADDR_STATUS) begin
                rd_next[0] = stat_reg;
            end else if (paddr == `SBT_ADDR_MASK) begin
                rd_next[0] = mask_reg;
            end
        end
        ctl_next[`SBT_BIT_SYSCLK] = sys_reg;
        irq_next = stat_next & mask_next;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= `SBT_CTL_RESET;
            cnt_reg <= 16'h0000;
            hbuf_reg <= 8'h00;
            ps_reg <= 3'h0;
            q_reg <= 2'h0;
            stat_reg <= 1'b0;
            mask_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
            sys_reg <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            lp_osc_power <= 1'b0;
            pins_forced_input <= 1'b0;
        end else begin
            ctl_reg <= ctl_next;
            cnt_reg <= cnt_next;
            hbuf_reg <= hbuf_next;
            ps_reg <= ps_next;
            q_reg <= q_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            rd_reg <= rd_next;
            irq_reg <= irq_next;
            sys_reg <= sys_next;
            pready <= 1'b1;
            pslverr <= 1'b0;
            lp_osc_power <= ctl_next[`SBT_BIT_OSC_EN];
            pins_forced_input <= ctl_next[`SBT_BIT_RUN];
        end
    end
    assign prdata = rd_reg;
    assign irq = irq_reg;

    // ****************************************
    // Assertions
    // ****************************************
    property p_wide_low_read;
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && wide && paddr == `SBT_ADDR_LOW)
            |=> hbuf_reg == $past(cnt_reg[15:8]);
    endproperty
    a_wide_low_read: assert property (p_wide_low_read)
        else $error("Buffer not loaded on low read");
    property p_wide_low_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_ok && wide && paddr == `SBT_ADDR_LOW)
            |=> cnt_reg == {$past(hbuf_reg), $past(pwdata[7:0])};
    endproperty
    a_wide_low_write: assert property (p_wide_low_write)
        else $error("Wide write did not load both bytes");
    property p_wide_high_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_ok && wide && paddr == `SBT_ADDR_HIGH && !compare_trigger)
            |=> cnt_reg[15:8] == $past(cnt_reg[15:8])
                || $past(ps_hit);
    endproperty
    a_wide_high_write: assert property (p_wide_high_write)
        else $error("Live high byte written in wide mode");
    property p_narrow_high_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_ok && !wide && paddr == `SBT_ADDR_HIGH)
            |=> cnt_reg[15:8] == $past(pwdata[7:0]);
    endproperty
    a_narrow_high_write: assert property (p_narrow_high_write)
        else $error("Narrow high write lost");
    property p_low_write_ps;
        @(posedge pclk) disable iff (!presetn)
        (wr_ok && paddr == `SBT_ADDR_LOW) |=> ps_reg == 3'h0;
    endproperty
    a_low_write_ps: assert property (p_low_write_ps)
        else $error("Prescaler not cleared");
    property p_stopped;
        @(posedge pclk) disable iff (!presetn)
        (!ctl_reg[`SBT_BIT_RUN] && !wr_ok && !compare_trigger)
            |=> cnt_reg == $past(cnt_reg);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("Counter moved while stopped");
    property p_overflow;
        @(posedge pclk) disable iff (!presetn)
        (ps_hit && cnt_reg == `SBT_COUNT_MAX)
            |=> stat_reg && irq == mask_reg;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("Overflow not latched");
    property p_pins;
        @(posedge pclk) disable iff (!presetn)
        ctl_reg[`SBT_BIT_RUN] |-> pins_forced_input;
    endproperty
    a_pins: assert property (p_pins)
        else $error("Pins not forced to input");
    property p_trigger_clear;
        @(posedge pclk) disable iff (!presetn)
        (trig_ok && !wr_ok) |=> cnt_reg == 16'h0000;
    endproperty
    a_trigger_clear: assert property (p_trigger_clear)
        else $error("Trigger did not clear the count");
    property p_high_write_ps;
        @(posedge pclk) disable iff (!presetn)
        (wr_ok && paddr == `SBT_ADDR_HIGH && !tick)
            |=> ps_reg == $past(ps_reg);
    endproperty
    a_high_write_ps: assert property (p_high_write_ps)
        else $error("High write moved the prescaler");
    c_wide_read: cover property (@(posedge pclk) disable iff (!presetn)
        rd_setup && wide && paddr == `SBT_ADDR_LOW);
    c_overflow: cover property (@(posedge pclk) disable iff (!presetn)
        stat_reg && irq);
    c_wide_rw: cover property (@(posedge pclk) disable iff (!presetn)
        wr_ok && wide && paddr == `SBT_ADDR_LOW);
    c_trigger: cover property (@(posedge pclk) disable iff (!presetn)
        compare_trigger && ctl_reg[`SBT_BIT_RUN]);
endmodule // sbt_timer
`default_nettype wire

// >>> tb_sbt_timer.sv
// Self-checking testbench for the sixteen bit timer counter
`timescale 1ns/1ps
`default_nettype none
`include "sbt_regs.svh"
module tb_sbt_timer;
    // Expected read value and the bits that matter
    typedef struct {logic [31:0] e; logic [31:0] m;} sbt_note_type;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ext_count_pin = 1'b0;
    logic lp_osc_in = 1'b0;
    logic sysclk_src_lp = 1'b0;
    logic compare_trigger = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, lp_osc_power, pins_forced_input, irq;
    sbt_note_type notes[$]; // Reads still waiting for data
    sbt_note_type note;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'he81b;
    logic [31:0] v;

    sbt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(ext_count_pin),
        .lp_osc_in(lp_osc_in), .sysclk_src_lp(sysclk_src_lp),
        .compare_trigger(compare_trigger), .lp_osc_power(lp_osc_power),
        .pins_forced_input(pins_forced_input), .irq(irq));

    // ************************************************************
    // Clock, compare and bus tasks
    // ************************************************************
    always #20 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One transfer; an idle cycle always separates two of them
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Note the expectation first; the monitor takes it later
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        notes.push_back('{e, m});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Rising edges on the pin or the oscillator input, 3 cycles a level
    task automatic edges(input logic osc, input int n);
        repeat (n) begin
            @(posedge pclk);
            ext_count_pin <= !osc;
            lp_osc_in <= osc;
            tick(3);
            ext_count_pin <= 1'b0;
            lp_osc_in <= 1'b0;
            tick(2);
        end
    endtask

    // Read data stands in the access phase; taken at the completing edge
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            chk("pslverr", 32'h0, 32'(pslverr));
            if (!pwrite) begin
                note = notes.pop_front();
                chk("prdata", note.e, prdata & note.m);
            end
        end
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs under a thousand cycles
    initial begin
        tick(20000);
        err_total++;
        close_out();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        tick(6);
        presetn <= 1'b1;
        tick(2);
        rd(`SBT_ADDR_CONTROL, 32'h0, 32'hff);
        wr(`SBT_ADDR_CONTROL, 32'hc0);
        rd(`SBT_ADDR_CONTROL, 32'h80, 32'hff);
        sysclk_src_lp <= 1'b1;
        tick(4);
        rd(`SBT_ADDR_CONTROL, 32'hc0, 32'hff);
        sysclk_src_lp <= 1'b0;
        // Wide mode: a later high write only touches the buffer
        v = $random(seed);
        wr(`SBT_ADDR_HIGH, {24'h0, v[15:8]});
        wr(`SBT_ADDR_LOW, {24'h0, v[7:0]});
        wr(`SBT_ADDR_HIGH, {24'h0, v[31:24]});
        rd(`SBT_ADDR_HIGH, {24'h0, v[31:24]}, 32'hff);
        rd(`SBT_ADDR_LOW, {24'h0, v[7:0]}, 32'hff);
        rd(`SBT_ADDR_HIGH, {24'h0, v[15:8]}, 32'hff);
        wr(`SBT_ADDR_CONTROL, 32'h0);
        rd(`SBT_ADDR_HIGH, {24'h0, v[15:8]}, 32'hff);
        // Narrow mode: bytes are independent
        v = $random(seed);
        wr(`SBT_ADDR_HIGH, {24'h0, v[7:0]});
        wr(`SBT_ADDR_LOW, {24'h0, v[23:16]});
        rd(`SBT_ADDR_LOW, {24'h0, v[23:16]}, 32'hff);
        rd(`SBT_ADDR_HIGH, {24'h0, v[7:0]}, 32'hff);
        // Every prescale ratio on synchronised pin edges
        for (int ps = 0; ps < 4; ps++) begin
            wr(`SBT_ADDR_CONTROL, 32'h0);
            wr(`SBT_ADDR_HIGH, 32'h0);
            wr(`SBT_ADDR_LOW, 32'h0);
            wr(`SBT_ADDR_CONTROL, 32'({ps[1:0], 4'h3}));
            edges(1'b0, 16);
            rd(`SBT_ADDR_LOW, 32'(16 >> ps), 32'hff);
        end
        // Unsynchronised setting still counts every pin rise
        wr(`SBT_ADDR_CONTROL, 32'h0);
        wr(`SBT_ADDR_LOW, 32'h0);
        wr(`SBT_ADDR_CONTROL, 32'h07);
        edges(1'b0, 3);
        wr(`SBT_ADDR_CONTROL, 32'h0);
        rd(`SBT_ADDR_LOW, 32'h3, 32'hff);
        // Oscillator edges, oscillator powered
        wr(`SBT_ADDR_CONTROL, 32'h0);
        wr(`SBT_ADDR_LOW, 32'h0);
        wr(`SBT_ADDR_CONTROL, 32'h0b);
        tick(1);
        #1 chk("lp_osc_power", 32'h1, 32'(lp_osc_power));
        edges(1'b1, 5);
        wr(`SBT_ADDR_CONTROL, 32'h0);
        rd(`SBT_ADDR_LOW, 32'h5, 32'hff);
        #1 chk("lp_osc_power", 32'h0, 32'(lp_osc_power));
        // Internal clock across the rollover
        wr(`SBT_ADDR_HIGH, 32'hff);
        wr(`SBT_ADDR_LOW, 32'hfe);
        wr(`SBT_ADDR_MASK, 32'h1);
        wr(`SBT_ADDR_CONTROL, 32'h1);
        tick(1);
        #1 chk("pins_forced_input", 32'h1, 32'(pins_forced_input));
        tick(30);
        #1 chk("irq", 32'h1, 32'(irq));
        wr(`SBT_ADDR_CONTROL, 32'h0);
        rd(`SBT_ADDR_HIGH, 32'h0, 32'hff);
        rd(`SBT_ADDR_STATUS, 32'h1, 32'h1);
        #1 chk("pins_forced_input", 32'h0, 32'(pins_forced_input));
        wr(`SBT_ADDR_MASK, 32'h0);
        tick(2);
        #1 chk("irq", 32'h0, 32'(irq));
        wr(`SBT_ADDR_MASK, 32'h1);
        tick(2);
        #1 chk("irq", 32'h1, 32'(irq));
        wr(`SBT_ADDR_STATUS, 32'h1);
        tick(2);
        #1 chk("irq", 32'h0, 32'(irq));
        // Trigger clears a running count without an overflow
        wr(`SBT_ADDR_HIGH, 32'h12);
        wr(`SBT_ADDR_LOW, 32'h34);
        wr(`SBT_ADDR_CONTROL, 32'h3);
        @(posedge pclk);
        compare_trigger <= 1'b1;
        @(posedge pclk);
        compare_trigger <= 1'b0;
        wr(`SBT_ADDR_CONTROL, 32'h0);
        rd(`SBT_ADDR_LOW, 32'h0, 32'hff);
        rd(`SBT_ADDR_HIGH, 32'h0, 32'hff);
        rd(`SBT_ADDR_STATUS, 32'h0, 32'h1);
        // Timer mode with the sync bit set still takes the trigger
        wr(`SBT_ADDR_LOW, 32'h56);
        wr(`SBT_ADDR_CONTROL, 32'h35);
        @(posedge pclk);
        compare_trigger <= 1'b1;
        @(posedge pclk);
        compare_trigger <= 1'b0;
        wr(`SBT_ADDR_CONTROL, 32'h0);
        rd(`SBT_ADDR_LOW, 32'h0, 32'hff);
        // A low write on the trigger's edge keeps its byte
        fork
            wr(`SBT_ADDR_LOW, 32'h78);
            begin
                tick(2);
                compare_trigger <= 1'b1;
                tick(1);
                compare_trigger <= 1'b0;
            end
        join
        rd(`SBT_ADDR_LOW, 32'h78, 32'hff);
        // Unmapped place ignores writes and reads zero
        wr(8'h14, 32'hffffffff);
        rd(8'h14, 32'h0, 32'hffffffff);
        tick(3);
        close_out();
    end
endmodule // tb_sbt_timer
`default_nettype wire
